// File: design/uemr_pkg.sv
// Package with constants and types for the endpoint mode responder
package uemr_pkg;
	localparam int unsigned NUM_EP       = 3;
	localparam int unsigned EP_IDX_W     = 2;
	localparam int unsigned MODE_W       = 4;
	localparam int unsigned CNT_W        = 4;
	// Register byte addresses
	localparam logic [7:0] ADDR_EP0_MODE = 8'h00;
	localparam logic [7:0] ADDR_EP1_MODE = 8'h04;
	localparam logic [7:0] ADDR_EP2_MODE = 8'h08;
	localparam logic [7:0] ADDR_EP0_CNT  = 8'h0c;
	localparam logic [7:0] ADDR_EP1_CNT  = 8'h10;
	localparam logic [7:0] ADDR_EP2_CNT  = 8'h14;
	localparam logic [7:0] ADDR_STATUS   = 8'h18;
	// Field positions, reset values and response codes
	localparam int unsigned HALT_BIT     = 7;
	localparam int unsigned SETUP_BIT    = 0;
	localparam logic [7:0]  MODE_RST     = 8'h00;
	localparam logic [3:0]  CNT_RST      = 4'h0;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;
	// Mode codes
	localparam logic [3:0] M_DISABLE     = 4'b0000;
	localparam logic [3:0] M_NAK_IO      = 4'b0001;
	localparam logic [3:0] M_STATUS_OUT  = 4'b0010;
	localparam logic [3:0] M_STALL_IO    = 4'b0011;
	localparam logic [3:0] M_STATUS_IN   = 4'b0110;
	localparam logic [3:0] M_ACKOUT_STIN = 4'b1011;
	localparam logic [3:0] M_ACKIN_STOUT = 4'b1111;
	localparam logic [3:0] M_NAK_OUT     = 4'b1000;
	localparam logic [3:0] M_ACK_OUT     = 4'b1001;
	localparam logic [3:0] M_NAK_IN      = 4'b1100;
	localparam logic [3:0] M_ACK_IN      = 4'b1101;

	typedef enum logic [1:0]
	{
		TOK_SETUP = 2'b00,
		TOK_IN    = 2'b01,
		TOK_OUT   = 2'b10
	} uemr_tok_t;

	typedef enum logic [2:0]
	{
		RSP_NONE  = 3'b000,
		RSP_ACK   = 3'b001,
		RSP_NAK   = 3'b010,
		RSP_STALL = 3'b011,
		RSP_TX0   = 3'b100,
		RSP_TXCNT = 3'b101
	} uemr_rsp_t;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_DATA = 2'b01,
		ST_WAIT = 2'b10
	} uemr_st_t;

	// Token from the packet layer
	typedef struct packed
	{
		logic      valid;
		uemr_tok_t tok;
		logic [1:0] ep;
	} uemr_token_t;

	// OUT/SETUP data phase summary
	typedef struct packed
	{
		logic       valid;
		logic       crc_ok;
		logic       toggle;
		logic [3:0] len;
	} uemr_data_t;

	// Reply request to the transmitter
	typedef struct packed
	{
		logic       valid;
		uemr_rsp_t  rsp;
		logic [3:0] count;
		logic [1:0] ep;
	} uemr_reply_t;

	typedef struct packed
	{
		uemr_st_t   st;
		uemr_tok_t  tok;
		logic [1:0] ep;
		logic [3:0] mode;
		logic       halt;
		logic [2:0][7:0] ep_mode;
		logic [2:0][3:0] ep_cnt;
		logic       setup_rx;
		logic       aw_got;
		logic       w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		uemr_reply_t reply;
	} uemr_state_t;
endpackage

// File: design/uemr_responder.sv
// Endpoint mode responder: token reply selection and mode registers
`timescale 1ns/1ps
module uemr_responder
(
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_resetn,
	input  wire logic [7:0]           i_awaddr,
	input  wire logic                 i_awvalid,
	output logic                      o_awready,
	input  wire logic [31:0]          i_wdata,
	input  wire logic [3:0]           i_wstrb,
	input  wire logic                 i_wvalid,
	output logic                      o_wready,
	output logic                      o_bvalid,
	output logic [1:0]                o_bresp,
	input  wire logic                 i_bready,
	input  wire logic [7:0]           i_araddr,
	input  wire logic                 i_arvalid,
	output logic                      o_arready,
	output logic                      o_rvalid,
	output logic [31:0]               o_rdata,
	output logic [1:0]                o_rresp,
	input  wire logic                 i_rready,
	input  wire uemr_pkg::uemr_token_t i_token,
	input  wire uemr_pkg::uemr_data_t  i_data,
	input  wire logic                 i_host_ack,
	input  wire logic                 i_host_timeout,
	output uemr_pkg::uemr_reply_t     o_reply,
	output logic                      o_ctrl_buf_wr_block
);

	uemr_pkg::uemr_state_t s_r;
	uemr_pkg::uemr_state_t s_nxt;

	////////////////////////////////////////////////////////////////////////
	// Reply for a token given the sampled mode and halt bit
	function automatic uemr_pkg::uemr_rsp_t tok_reply(
		input uemr_pkg::uemr_tok_t tok,
		input logic [3:0]          mode,
		input logic                halt);
		uemr_pkg::uemr_rsp_t r;
		r = uemr_pkg::RSP_NONE;
		case (mode)
			uemr_pkg::M_NAK_IO, uemr_pkg::M_STATUS_OUT,
			uemr_pkg::M_STALL_IO, uemr_pkg::M_STATUS_IN,
			uemr_pkg::M_ACKOUT_STIN, uemr_pkg::M_ACKIN_STOUT:
			begin
				// Control modes: SETUP settles after its data phase
				if (tok == uemr_pkg::TOK_IN)
				begin
					case (mode)
						uemr_pkg::M_NAK_IO:      r = uemr_pkg::RSP_NAK;
						uemr_pkg::M_STATUS_OUT:  r = uemr_pkg::RSP_STALL;
						uemr_pkg::M_STALL_IO:    r = uemr_pkg::RSP_STALL;
						uemr_pkg::M_STATUS_IN:   r = uemr_pkg::RSP_TX0;
						uemr_pkg::M_ACKOUT_STIN: r = uemr_pkg::RSP_TX0;
						default:                 r = uemr_pkg::RSP_TXCNT;
					endcase
				end
			end
			uemr_pkg::M_NAK_IN:
				if (tok == uemr_pkg::TOK_IN)
					r = uemr_pkg::RSP_NAK;
			uemr_pkg::M_ACK_IN:
				if (tok == uemr_pkg::TOK_IN)
					r = halt ? uemr_pkg::RSP_STALL
					         : uemr_pkg::RSP_TXCNT;
			default: r = uemr_pkg::RSP_NONE;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reply after an OUT or SETUP data phase
	function automatic uemr_pkg::uemr_rsp_t data_reply(
		input uemr_pkg::uemr_tok_t tok,
		input logic [3:0]          mode,
		input logic                halt,
		input uemr_pkg::uemr_data_t d);
		uemr_pkg::uemr_rsp_t r;
		logic ctrl;
		r = uemr_pkg::RSP_NONE;
		ctrl = (mode == uemr_pkg::M_NAK_IO) || (mode == uemr_pkg::M_STATUS_OUT)
			|| (mode == uemr_pkg::M_STALL_IO) || (mode == uemr_pkg::M_STATUS_IN)
			|| (mode == uemr_pkg::M_ACKOUT_STIN)
			|| (mode == uemr_pkg::M_ACKIN_STOUT);
		if (d.crc_ok)
		begin
			if (tok == uemr_pkg::TOK_SETUP)
				r = ctrl ? uemr_pkg::RSP_ACK : uemr_pkg::RSP_NONE;
			else
			begin
				case (mode)
					uemr_pkg::M_NAK_IO:      r = uemr_pkg::RSP_NAK;
					uemr_pkg::M_STALL_IO:    r = uemr_pkg::RSP_STALL;
					uemr_pkg::M_STATUS_IN:   r = uemr_pkg::RSP_STALL;
					uemr_pkg::M_ACKOUT_STIN: r = uemr_pkg::RSP_ACK;
					uemr_pkg::M_STATUS_OUT, uemr_pkg::M_ACKIN_STOUT:
						// Zero payload and DATA1 only
						r = (d.len == 4'h0 && d.toggle) ? uemr_pkg::RSP_ACK
						                                : uemr_pkg::RSP_STALL;
					uemr_pkg::M_NAK_OUT:     r = uemr_pkg::RSP_NAK;
					uemr_pkg::M_ACK_OUT:
						r = halt ? uemr_pkg::RSP_STALL
						         : uemr_pkg::RSP_ACK;
					default:                 r = uemr_pkg::RSP_NONE;
				endcase
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: transaction sequencer plus AXI4-Lite slave
	always_comb
	begin
		logic [7:0]  ep_w;
		logic        sw_wr;
		logic        hw_wr;
		logic [1:0]  hw_ep;
		logic [3:0]  hw_mode;
		uemr_pkg::uemr_rsp_t rsp;
		ep_w    = 8'h00;
		sw_wr   = 1'b0;
		hw_wr   = 1'b0;
		hw_ep   = 2'b00;
		hw_mode = 4'h0;
		rsp     = uemr_pkg::RSP_NONE;
		s_nxt   = s_r;
		s_nxt.reply.valid = 1'b0;

		case (s_r.st)
			uemr_pkg::ST_IDLE:
				if (i_token.valid && i_token.ep != 2'b11)
				begin
					// Mode frozen here for the whole transaction
					s_nxt.tok  = i_token.tok;
					s_nxt.ep   = i_token.ep;
					s_nxt.mode = s_r.ep_mode[i_token.ep][3:0];
					s_nxt.halt = s_r.ep_mode[i_token.ep][uemr_pkg::HALT_BIT];
					if (i_token.tok == uemr_pkg::TOK_IN)
					begin
						rsp = tok_reply(i_token.tok, s_r.ep_mode[i_token.ep][3:0],
							s_r.ep_mode[i_token.ep][uemr_pkg::HALT_BIT]);
						s_nxt.reply.valid = (rsp != uemr_pkg::RSP_NONE);
						s_nxt.reply.rsp   = rsp;
						s_nxt.reply.ep    = i_token.ep;
						s_nxt.reply.count = (rsp == uemr_pkg::RSP_TXCNT)
							? s_r.ep_cnt[i_token.ep] : 4'h0;
						if (rsp == uemr_pkg::RSP_TXCNT || rsp == uemr_pkg::RSP_TX0)
							s_nxt.st = uemr_pkg::ST_WAIT;
					end
					else
						s_nxt.st = uemr_pkg::ST_DATA;
				end
			uemr_pkg::ST_DATA:
				if (i_data.valid)
				begin
					rsp = data_reply(s_r.tok, s_r.mode, s_r.halt, i_data);
					s_nxt.reply.valid = (rsp != uemr_pkg::RSP_NONE);
					s_nxt.reply.rsp   = rsp;
					s_nxt.reply.ep    = s_r.ep;
					s_nxt.reply.count = 4'h0;
					s_nxt.st = uemr_pkg::ST_IDLE;
					if (s_r.tok == uemr_pkg::TOK_SETUP && rsp == uemr_pkg::RSP_ACK)
						s_nxt.setup_rx = 1'b1;
					if (rsp == uemr_pkg::RSP_ACK && s_r.mode == uemr_pkg::M_ACK_OUT)
					begin
						hw_wr   = 1'b1;
						hw_ep   = s_r.ep;
						hw_mode = uemr_pkg::M_NAK_OUT;
					end
				end
			uemr_pkg::ST_WAIT:
				if (i_host_ack || i_host_timeout)
				begin
					s_nxt.st = uemr_pkg::ST_IDLE;
					if (i_host_ack && s_r.mode == uemr_pkg::M_ACK_IN && !s_r.halt)
					begin
						hw_wr   = 1'b1;
						hw_ep   = s_r.ep;
						hw_mode = uemr_pkg::M_NAK_IN;
					end
				end
			default: s_nxt.st = uemr_pkg::ST_IDLE;
		endcase

		// Write channel: address and data taken in either order
		if (i_awvalid && !s_r.aw_got && !s_r.bvalid)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = i_awaddr;
		end
		if (i_wvalid && !s_r.w_got && !s_r.bvalid)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = i_wdata;
		end
		sw_wr = s_r.aw_got && s_r.w_got && !s_r.bvalid;
		if (sw_wr)
		begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = uemr_pkg::RESP_OKAY;
			ep_w = s_r.wdata[7:0];
			case (s_r.awaddr)
				uemr_pkg::ADDR_EP0_MODE: s_nxt.ep_mode[0] = {4'h0, ep_w[3:0]};
				uemr_pkg::ADDR_EP1_MODE:
					if (!hw_wr) // Shared update path: engine wins
						s_nxt.ep_mode[1] = ep_w;
				uemr_pkg::ADDR_EP2_MODE:
					if (!hw_wr)
						s_nxt.ep_mode[2] = ep_w;
				uemr_pkg::ADDR_EP0_CNT:  s_nxt.ep_cnt[0] = ep_w[3:0];
				uemr_pkg::ADDR_EP1_CNT:  s_nxt.ep_cnt[1] = ep_w[3:0];
				uemr_pkg::ADDR_EP2_CNT:  s_nxt.ep_cnt[2] = ep_w[3:0];
				uemr_pkg::ADDR_STATUS:
					if (ep_w[uemr_pkg::SETUP_BIT])
						s_nxt.setup_rx = 1'b0;
				default: s_nxt.bresp = uemr_pkg::RESP_SLVERR;
			endcase
		end
		if (s_r.bvalid && i_bready)
			s_nxt.bvalid = 1'b0;
		// Engine update applied last so it always wins
		if (hw_wr)
			s_nxt.ep_mode[hw_ep][3:0] = hw_mode;
		// A new SETUP in the clear cycle keeps the flag set
		if (s_r.st == uemr_pkg::ST_DATA && i_data.valid
			&& s_r.tok == uemr_pkg::TOK_SETUP && rsp == uemr_pkg::RSP_ACK)
			s_nxt.setup_rx = 1'b1;

		// Read channel
		if (i_arvalid && !s_r.rvalid)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = uemr_pkg::RESP_OKAY;
			case (i_araddr)
				uemr_pkg::ADDR_EP0_MODE: s_nxt.rdata = {24'h0, s_r.ep_mode[0]};
				uemr_pkg::ADDR_EP1_MODE: s_nxt.rdata = {24'h0, s_r.ep_mode[1]};
				uemr_pkg::ADDR_EP2_MODE: s_nxt.rdata = {24'h0, s_r.ep_mode[2]};
				uemr_pkg::ADDR_EP0_CNT:  s_nxt.rdata = {28'h0, s_r.ep_cnt[0]};
				uemr_pkg::ADDR_EP1_CNT:  s_nxt.rdata = {28'h0, s_r.ep_cnt[1]};
				uemr_pkg::ADDR_EP2_CNT:  s_nxt.rdata = {28'h0, s_r.ep_cnt[2]};
				uemr_pkg::ADDR_STATUS:   s_nxt.rdata = {31'h0, s_r.setup_rx};
				default:
				begin
					s_nxt.rdata = 32'h0;
					s_nxt.rresp = uemr_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_r.rvalid && i_rready)
			s_nxt.rvalid = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			s_r <= '0;
			s_r.ep_mode <= {3{uemr_pkg::MODE_RST}};
			s_r.ep_cnt  <= {3{uemr_pkg::CNT_RST}};
		end
		else
			s_r <= s_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs; ready signals are combinational handshakes
	assign o_awready = !s_r.aw_got && !s_r.bvalid;
	assign o_wready  = !s_r.w_got && !s_r.bvalid;
	assign o_arready = !s_r.rvalid;
	assign o_bvalid  = s_r.bvalid;
	assign o_bresp   = s_r.bresp;
	assign o_rvalid  = s_r.rvalid;
	assign o_rdata   = s_r.rdata;
	assign o_rresp   = s_r.rresp;
	assign o_reply   = s_r.reply;
	assign o_ctrl_buf_wr_block = s_r.setup_rx;

endmodule

// File: verif/uemr_responder_assertions.sv
// Port-level checker for the endpoint mode responder
`timescale 1ns/1ps
module uemr_responder_assertions
(
	input	wire logic			i_sys_clk,
	input	wire logic			i_resetn,
	input	wire logic			o_awready,
	input	wire logic			o_wready,
	input	wire logic			o_bvalid,
	input	wire logic			i_bready,
	input	wire logic			o_arready,
	input	wire logic			o_rvalid,
	input	wire logic			i_rready,
	input	wire uemr_pkg::uemr_token_t	i_token,
	input	wire uemr_pkg::uemr_data_t	i_data,
	input	wire uemr_pkg::uemr_reply_t	o_reply,
	input	wire logic			o_ctrl_buf_wr_block
);
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);
	////////////////////////////////////////
	// Causes flattened so that $past sees plain signals
	logic	cause;
	logic	setup_ack;
	assign cause = i_data.valid
		| (i_token.valid & (i_token.tok == uemr_pkg::TOK_IN));
	assign setup_ack = o_reply.valid & (o_reply.ep == 2'h0)
		& (o_reply.rsp == uemr_pkg::RSP_ACK);
	// Token side
	property p_reply_pulse;
		o_reply.valid |=> !o_reply.valid;
	endproperty
	a_reply_pulse: assert property (p_reply_pulse)
		else $error("reply valid held too long");
	property p_reply_cause;
		o_reply.valid |-> $past(cause);
	endproperty
	a_reply_cause: assert property (p_reply_cause)
		else $error("reply without token or data phase");
	property p_ep3;
		i_token.valid && i_token.ep == 2'h3 |=> !o_reply.valid;
	endproperty
	a_ep3: assert property (p_ep3)
		else $error("reply to absent endpoint");
	property p_flag_cause;
		$rose(o_ctrl_buf_wr_block) |-> setup_ack || $past(setup_ack);
	endproperty
	a_flag_cause: assert property (p_flag_cause)
		else $error("setup flag rose without setup ack");
	// Register bus side
	property p_b_done;
		o_bvalid && i_bready |=> !o_bvalid;
	endproperty
	a_b_done: assert property (p_b_done)
		else $error("write response repeated");
	property p_r_done;
		o_rvalid && i_rready |=> !o_rvalid;
	endproperty
	a_r_done: assert property (p_r_done)
		else $error("read response repeated");
	property p_ar_block;
		o_rvalid |-> !o_arready;
	endproperty
	a_ar_block: assert property (p_ar_block)
		else $error("read address taken while busy");
	property p_aw_block;
		o_bvalid |-> !o_awready && !o_wready;
	endproperty
	a_aw_block: assert property (p_aw_block)
		else $error("write taken while response pending");
endmodule
bind uemr_responder uemr_responder_assertions u_chk (.*);

// File: verif/uemr_host_model.sv
// Host side model: tokens, data phase summaries and handshakes
`timescale 1ns/1ps
module uemr_host_model
(
	input	wire logic			i_sys_clk,
	output	uemr_pkg::uemr_token_t		o_token,
	output	uemr_pkg::uemr_data_t		o_data,
	output	logic				o_host_ack,
	output	logic				o_host_timeout
);
	// Idle at time zero
	initial
	begin
		o_token = '0;
		o_data = '0;
		o_host_ack = 1'b0;
		o_host_timeout = 1'b0;
	end
	// Token and data pulses invert their fields afterwards so no stale value lingers; handshakes return low
	task automatic token(input logic [1:0] t, input logic [1:0] ep);
		o_token <= {1'b1, t, ep};
		@(posedge i_sys_clk);
		o_token <= {1'b0, ~t, ~ep};
	endtask
	task automatic data(input logic crc, input logic tog, input logic [3:0] n);
		o_data <= {1'b1, crc, tog, n};
		@(posedge i_sys_clk);
		o_data <= {1'b0, ~crc, ~tog, ~n};
	endtask
	task automatic hs(input logic a);
		o_host_ack <= a;
		o_host_timeout <= !a;
		@(posedge i_sys_clk);
		o_host_ack <= 1'b0;
		o_host_timeout <= 1'b0;
	endtask
endmodule

// File: verif/uemr_responder_bench.sv
// Self-checking bench for the endpoint mode responder
`timescale 1ns/1ps
module uemr_responder_bench;
	logic	i_sys_clk, i_resetn, i_awvalid, i_wvalid, i_bready;
	logic	i_arvalid, i_rready, i_host_ack, i_host_timeout;
	logic	o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic	o_ctrl_buf_wr_block;
	logic [7:0]	i_awaddr, i_araddr;
	logic [31:0]	i_wdata, o_rdata;
	logic [3:0]	i_wstrb;
	logic [1:0]	o_bresp, o_rresp;
	uemr_pkg::uemr_token_t	i_token;
	uemr_pkg::uemr_data_t	i_data;
	uemr_pkg::uemr_reply_t	o_reply;
	int	fails = 0;
	int	cmp_count = 0;
	logic [3:0]	cnts [3] = '{4'hf, 4'h5, 4'h9};
	// Codes 4,5,7,a,e break the firmware contract on purpose
	logic [3:0]	cm [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'hb, 4'hf,
		4'h4, 4'h5, 4'h7, 4'ha, 4'he};
	logic [3:0]	dm [6] = '{4'h8, 4'h9, 4'hc, 4'hd, 4'h4, 4'he};
	uemr_responder dut (.*);
	uemr_host_model host (.i_sys_clk(i_sys_clk), .o_token(i_token),
		.o_data(i_data), .o_host_ack(i_host_ack),
		.o_host_timeout(i_host_timeout));
	////////////////////////////////////////
	// 25 MHz clock
	initial
	begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Register access; reads compare data, both compare the response
	task automatic bus(logic we, logic [7:0] a, logic [31:0] d, logic [1:0] er);
		logic ta, tw;
		ta = 1'b0;
		tw = !we;
		i_awaddr <= a;
		i_araddr <= a;
		i_wdata <= d;
		i_awvalid <= we;
		i_wvalid <= we;
		i_arvalid <= !we;
		while (!(ta && tw))
		begin
			@(negedge i_sys_clk);
			ta = ta | (i_awvalid & o_awready) | (i_arvalid & o_arready);
			tw = tw | (i_wvalid & o_wready);
			@(posedge i_sys_clk);
			if (ta)
				i_awvalid <= 1'b0;
			if (ta)
				i_arvalid <= 1'b0;
			if (tw)
				i_wvalid <= 1'b0;
		end
		// Ready raised only here so the release below never meets a raise
		i_bready <= we;
		i_rready <= !we;
		@(negedge i_sys_clk);
		while ((we ? o_bvalid : o_rvalid) !== 1'b1)
			@(negedge i_sys_clk);
		chk("resp", 32'(er), 32'(we ? o_bresp : o_rresp));
		if (!we)
			chk("rdata", d, o_rdata);
		@(posedge i_sys_clk);
		i_bready <= 1'b0;
		i_rready <= 1'b0;
	endtask
	// Reply codes: 1 ACK, 2 NAK, 3 STALL, 4 zero bytes, 5 counted data
	function automatic logic [2:0] exp_rsp(logic [3:0] m, int t, logic h);
		case (m)
			4'h1: return (t == 0) ? 3'h1 : 3'h2;
			4'h2: return (t == 1) ? 3'h3 : 3'h1;
			4'h3: return (t == 0) ? 3'h1 : 3'h3;
			4'h6: return (t == 0) ? 3'h1 : (t == 1) ? 3'h4 : 3'h3;
			4'hb: return (t == 1) ? 3'h4 : 3'h1;
			4'hf: return (t == 1) ? 3'h5 : 3'h1;
			4'h8: return (t == 2) ? 3'h2 : 3'h0;
			4'h9: return (t != 2) ? 3'h0 : h ? 3'h3 : 3'h1;
			4'hc: return (t == 1) ? 3'h2 : 3'h0;
			4'hd: return (t != 1) ? 3'h0 : h ? 3'h3 : 3'h5;
			default: return 3'h0;
		endcase
	endfunction
	// One host transaction; sw[4] rewrites the mode before the data phase
	task automatic txn(logic [1:0] ep, int t, logic tog, logic [3:0] n,
		logic crc, logic ack, logic [4:0] sw, output logic [2:0] r,
		output logic [3:0] c);
		host.token(2'(t), ep);
		if (sw[4])
			bus(1'b1, {4'h0, ep, 2'h0}, 32'(sw[3:0]), 2'h0);
		if (t != 1)
			host.data(crc, tog, n);
		r = 3'h0;
		c = 4'h0;
		repeat (3)
		begin
			@(negedge i_sys_clk);
			if (o_reply.valid === 1'b1)
			begin
				r = o_reply.rsp;
				c = o_reply.count;
				chk("reply ep", 32'(ep), 32'(o_reply.ep));
			end
		end
		@(posedge i_sys_clk);
		if (r[2])
			host.hs(ack);
		repeat (2)
			@(posedge i_sys_clk);
	endtask
	task automatic run(logic [1:0] ep, logic [3:0] m, logic h, int t);
		logic [2:0] r, e;
		logic [3:0] c, nm;
		e = exp_rsp(m, t, h);
		bus(1'b1, {4'h0, ep, 2'h0}, {24'h0, h, 3'h0, m}, 2'h0);
		txn(ep, t, t != 0, (t == 0) ? 4'h8 : 4'h0, 1'b1, 1'b1, 5'h0, r, c);
		chk("reply", 32'(e), 32'(r));
		if (e == 3'h5)
			chk("count", 32'(cnts[ep]), 32'(c));
		if (e == 3'h1 && t == 0)
			chk("setup flag", 32'h1, 32'(o_ctrl_buf_wr_block));
		bus(1'b1, 8'h18, 32'h1, 2'h0);
		chk("setup flag", 32'h0, 32'(o_ctrl_buf_wr_block));
		nm = (e == 3'h1 && m == 4'h9) ? 4'h8 : (e == 3'h5 && m == 4'hd) ? 4'hc : m;
		bus(1'b0, {4'h0, ep, 2'h0}, {24'h0, h, 3'h0, nm}, 2'h0);
	endtask
	task automatic odd(logic [1:0] ep, logic [3:0] m, int t, logic tog,
		logic [3:0] n, logic crc, logic ack, logic [4:0] sw, logic [2:0] e);
		logic [2:0] r;
		logic [3:0] c;
		bus(1'b1, {4'h0, ep, 2'h0}, 32'(m), 2'h0);
		txn(ep, t, tog, n, crc, ack, sw, r, c);
		chk("reply", 32'(e), 32'(r));
	endtask
	// Main sequence
	initial
	begin
		i_resetn = 1'b0;
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
		{i_awaddr, i_araddr, i_wdata} = '0;
		i_wstrb = 4'hf;
		repeat (12)
			@(posedge i_sys_clk);
		i_resetn <= 1'b1;
		@(posedge i_sys_clk);
		for (int a = 0; a < 7; a++)
			bus(1'b0, 8'(4 * a), 32'h0, 2'h0);
		bus(1'b0, 8'h1c, 32'h0, 2'h2);
		bus(1'b1, 8'h1c, 32'h5, 2'h2);
		for (int ep = 0; ep < 3; ep++)
			bus(1'b1, 8'(12 + 4 * ep), 32'(cnts[ep]), 2'h0);
		foreach (cm[i])
			for (int t = 0; t < 3; t++)
				run(2'h0, cm[i], 1'b0, t);
		// Halt only with receive or send modes
		for (int ep = 1; ep < 3; ep++)
			foreach (dm[i])
				for (int k = 0; k < 6; k++)
					if (k < 3 || dm[i] == 4'h9 || dm[i] == 4'hd)
						run(2'(ep), dm[i], k > 2, k % 3);
		odd(0, 4'h2, 2, 1, 4'h1, 1, 1, 0, 3'h3);
		odd(0, 4'h2, 2, 0, 4'h0, 1, 1, 0, 3'h3);
		odd(0, 4'hf, 2, 1, 4'h2, 1, 1, 0, 3'h3);
		odd(0, 4'h1, 0, 0, 4'h8, 0, 1, 0, 3'h0);
		odd(1, 4'hd, 1, 0, 4'h0, 1, 0, 0, 3'h5);
		bus(1'b0, 8'h04, 32'hd, 2'h0);
		odd(1, 4'h8, 2, 1, 4'h0, 1, 1, 5'h19, 3'h2);
		// Absent endpoint; the write lands on its own count value
		odd(3, 4'hf, 1, 0, 4'h0, 1, 1, 0, 3'h0);
		// Engine rewrite of one data mode blocks a same-cycle write to the other
		bus(1'b1, 8'h04, 32'h9, 2'h0);
		bus(1'b1, 8'h08, 32'h8, 2'h0);
		host.token(2'h2, 2'h1);
		fork
			begin
				@(posedge i_sys_clk);
				host.data(1'b1, 1'b1, 4'h0);
			end
			bus(1'b1, 8'h08, 32'hc, 2'h0);
		join
		bus(1'b0, 8'h08, 32'h8, 2'h0);
		bus(1'b0, 8'h04, 32'h8, 2'h0);
		print_verdict();
	end
	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (20000)
			@(posedge i_sys_clk);
		fails++;
		print_verdict();
	end
endmodule
